/* verilog/reload_timer_params.svh */
// constant definitions for the reload/capture timer
`ifndef RELOAD_TIMER_PARAMS_SVH
`define RELOAD_TIMER_PARAMS_SVH

// ============================================================
// bus geometry
`define APB_AW            12
`define APB_DW            32

// ============================================================
// register byte addresses
`define OFF_TIMER_CONTROL 12'h0C8
`define OFF_COUNT_LOW     12'h0CC
`define OFF_COUNT_HIGH    12'h0D0
`define OFF_RELOAD_LOW    12'h0D4
`define OFF_RELOAD_HIGH   12'h0D8
`define OFF_CLOCK_CONTROL 12'h0DC

// ============================================================
// timer_control bit positions
`define BIT_OVERFLOW      7
`define BIT_EXT_EDGE      6
`define BIT_RX_BAUD       5
`define BIT_TX_BAUD       4
`define BIT_EXT_ENABLE    3
`define BIT_RUN           2
`define BIT_COUNTER_SEL   1
`define BIT_CAPTURE_SEL   0

// ============================================================
// clock_control_register bit positions
`define BIT_IRQ_ENABLE    0
`define BIT_TICK_SPEED    5

// ============================================================
// reset values and count limits
`define CONTROL_RESET     8'h00
`define CLKCTRL_RESET     8'h00
`define COUNT_RESET       16'h0000
`define COUNT_MAX         16'hFFFF
`define COUNT_ONE         16'h0001
`define READ_ZERO         32'h0000_0000

// ============================================================
// tick divisors in core clocks
`define DIV_BAUD          4'h2
`define DIV_FAST          4'h4
`define DIV_SLOW          4'hC
`define PRESCALE_ZERO     4'h0
`define PRESCALE_ONE      4'h1

`endif

/* verilog/reload_timer_pkg.sv */
// types shared by the reload/capture timer modules
package reload_timer_pkg;

  // operating mode decoded from timer_control
  typedef enum logic [1:0] {
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } timer_mode_t;

  // state of the pin edge detector
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [1:0] fall;
  } edge_state_t;

  // state of the timer core
  typedef struct packed {
    logic [7:0]  timerControl;
    logic [7:0]  clockControl;
    logic [15:0] countVal;
    logic [15:0] reloadVal;
    logic [3:0]  prescale;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timerIrq;
    logic        rxBaudTick;
    logic        txBaudTick;
  } timer_state_t;

endpackage : reload_timer_pkg

/* verilog/pin_edge_if.sv */
// falling-edge events passed from the pin detector to the timer core
`timescale 1ns/100ps
`default_nettype none

interface pin_edge_if;
  logic countFall;
  logic trigFall;

  modport producer (output countFall, output trigFall);
  modport consumer (input countFall, input trigFall);
endinterface : pin_edge_if

`default_nettype wire

/* verilog/pin_edge_detect.sv */
// synchroniser and falling-edge detector for the two timer pins
`timescale 1ns/100ps
`default_nettype none

module pin_edge_detect
  import reload_timer_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic         countInputPin,
  input  wire logic         triggerPin,
  pin_edge_if.producer      ev
);

  edge_state_t s_q;
  edge_state_t s_d;

  // ============================================================
  // next state: sync1 feeds only sync2, edges come from sync2/prev
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = {triggerPin, countInputPin};
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.fall  = s_q.prev & ~s_q.sync2;
  end

  // ============================================================
  // state register; pins idle high so reset the chain to ones
  // to avoid a false edge right after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{sync1: 2'h3, sync2: 2'h3, prev: 2'h3, fall: 2'h0};
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // event outputs, one-cycle pulses from flops
  assign ev.countFall = s_q.fall[0];
  assign ev.trigFall  = s_q.fall[1];

endmodule : pin_edge_detect

`default_nettype wire

/* verilog/reload_capture_timer.sv */
// sixteen-bit reload/capture/baud timer with an apb register slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "reload_timer_params.svh"

// ============================================================
// one state struct holds the core; the pin detector feeds it
// one-cycle edge events through a small interface

// Functional notes
// - control register at C8, zero reset
// - rollover from FFFF sets sticky overflow flag
// - overflow flag requests interrupt when enabled
// - no overflow flag while either baud select set
// - software writing overflow one forces interrupt
// - enabled trigger falling edge sets edge flag; baud mode ignores the edge
// - software setting edge flag forces interrupt
// - receive baud select picks receiver timebase
// - transmit baud select picks transmitter timebase
// - baud mode advances every two clocks
// - pin enable off ignores trigger events
// - run bit starts, halt keeps count unless a trigger reload loads it
// - counter select: internal ticks or pin edges; baud mode ignores it
// - baud mode ignores capture select, reloads
// - reload on overflow, also trigger edge
// - capture mode captures on trigger edge
// - reload copies full sixteen bit value
// - reload happens at FFFF to 0000
// - capture copies count, sets flag, continues
// - capture mode overflow still sets flag
// - baud mode reloads from reload registers
module reload_capture_timer
  import reload_timer_pkg::*;
(
  input  wire logic [`APB_AW-1:0] paddr,
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [`APB_DW-1:0] pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [`APB_DW-1:0]      prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               countInputPin,
  input  wire logic               triggerPin,
  input  wire logic               timer1Overflow,
  output logic                    timerIrq,
  output logic                    rxBaudTick,
  output logic                    txBaudTick
);

  // ============================================================
  // helper functions
  // pure decoders shared by several processes

  // true when the bus address names one register word
  function automatic logic addrHit(
    input logic [`APB_AW-1:0] a,
    input logic [`APB_AW-1:0] off
  );
    addrHit = (a == off);
  endfunction : addrHit

  // true when the address falls on any mapped register
  function automatic logic addrMapped(input logic [`APB_AW-1:0] a);
    addrMapped = addrHit(a, `OFF_TIMER_CONTROL) |
                 addrHit(a, `OFF_COUNT_LOW)     |
                 addrHit(a, `OFF_COUNT_HIGH)    |
                 addrHit(a, `OFF_RELOAD_LOW)    |
                 addrHit(a, `OFF_RELOAD_HIGH)   |
                 addrHit(a, `OFF_CLOCK_CONTROL);
  endfunction : addrMapped

  // mode decode; baud selects override the capture select
  function automatic timer_mode_t decodeMode(input logic [7:0] ctl);
    if (ctl[`BIT_RX_BAUD] | ctl[`BIT_TX_BAUD]) begin
      decodeMode = MODE_BAUD;
    end else if (ctl[`BIT_CAPTURE_SEL]) begin
      decodeMode = MODE_CAPTURE;
    end else begin
      decodeMode = MODE_RELOAD;
    end
  endfunction : decodeMode

  // ============================================================
  // pin edge detection
  // two sync flops, a history flop and an edge flop: an event
  // shows three clocks after the pin falls
  pin_edge_if edges ();

  pin_edge_detect u_pin_edge_detect (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .clkEn         (clkEn),
    .countInputPin (countInputPin),
    .triggerPin    (triggerPin),
    .ev            (edges.producer)
  );

  // ============================================================
  // state
  // s_q holds every register, s_d its next value
  timer_state_t s_q;
  timer_state_t s_d;

  // decoded mode and bus strobes
  timer_mode_t  mode;
  logic         accessDone;
  logic         wrLane0;
  logic         wrControl;
  logic         wrCountLow;
  logic         wrCountHigh;
  logic         wrReloadLow;
  logic         wrReloadHigh;
  logic         wrClockCtrl;

  // tick and event strobes
  logic         running;
  logic [3:0]   divisor;
  logic         prescaleTick;
  logic         countTick;
  logic         rollover;
  logic         trigEvent;
  logic         doReload;
  logic         doCapture;
  logic         setOverflow;
  logic         setExtEdge;

  // control byte before hardware flag sets
  logic [7:0]   ctlBase;
  // read mux result, taken at the setup edge
  logic [`APB_DW-1:0] readWord;

  // ============================================================
  // bus decode and read mux
  always_comb begin
    // a transfer completes on the access edge with pready high
    accessDone   = psel & penable & s_q.pready;
    // only lane 0 carries data; other strobes are ignored
    wrLane0      = accessDone & pwrite & pstrb[0];
    wrControl    = wrLane0 & addrHit(paddr, `OFF_TIMER_CONTROL);
    wrCountLow   = wrLane0 & addrHit(paddr, `OFF_COUNT_LOW);
    wrCountHigh  = wrLane0 & addrHit(paddr, `OFF_COUNT_HIGH);
    wrReloadLow  = wrLane0 & addrHit(paddr, `OFF_RELOAD_LOW);
    wrReloadHigh = wrLane0 & addrHit(paddr, `OFF_RELOAD_HIGH);
    wrClockCtrl  = wrLane0 & addrHit(paddr, `OFF_CLOCK_CONTROL);

    // byte registers sit in the low lane, upper bits read zero
    readWord = `READ_ZERO;
    if (addrHit(paddr, `OFF_TIMER_CONTROL)) begin
      readWord[7:0] = s_q.timerControl;
    end else if (addrHit(paddr, `OFF_COUNT_LOW)) begin
      readWord[7:0] = s_q.countVal[7:0];
    end else if (addrHit(paddr, `OFF_COUNT_HIGH)) begin
      readWord[7:0] = s_q.countVal[15:8];
    end else if (addrHit(paddr, `OFF_RELOAD_LOW)) begin
      readWord[7:0] = s_q.reloadVal[7:0];
    end else if (addrHit(paddr, `OFF_RELOAD_HIGH)) begin
      readWord[7:0] = s_q.reloadVal[15:8];
    end else if (addrHit(paddr, `OFF_CLOCK_CONTROL)) begin
      readWord[7:0] = s_q.clockControl;
    end
  end

  // ============================================================
  // tick generation
  always_comb begin
    mode    = decodeMode(s_q.timerControl);
    running = s_q.timerControl[`BIT_RUN];

    // baud mode runs at a fixed half clock rate
    if (mode == MODE_BAUD) begin
      divisor = `DIV_BAUD;
    end else if (s_q.clockControl[`BIT_TICK_SPEED]) begin
      divisor = `DIV_FAST;
    end else begin
      divisor = `DIV_SLOW;
    end


    // limitation: halting drops any partial prescale count
    prescaleTick = running & (s_q.prescale == (divisor - `PRESCALE_ONE));


    // pin edges only count outside baud mode
    if (mode == MODE_BAUD) begin
      countTick = prescaleTick;
    end else if (s_q.timerControl[`BIT_COUNTER_SEL]) begin
      countTick = running & edges.countFall;
    end else begin
      countTick = prescaleTick;
    end
  end

  // ============================================================
  // count events: rollover, trigger reload and capture
  always_comb begin
    rollover  = countTick & (s_q.countVal == `COUNT_MAX);
    // trigger events are dropped when disabled or in baud mode
    trigEvent = edges.trigFall &
                s_q.timerControl[`BIT_EXT_ENABLE] &
                (mode != MODE_BAUD);


    // capture mode never reloads; it wraps to zero instead
    doReload  = (rollover & (mode != MODE_CAPTURE)) |
                (trigEvent & (mode == MODE_RELOAD));
    doCapture = trigEvent & (mode == MODE_CAPTURE);


    // flags: overflow only outside baud mode
    setOverflow = rollover & (mode != MODE_BAUD);
    setExtEdge  = trigEvent;
  end

  // ============================================================
  // next-state logic
  always_comb begin
    s_d = s_q;

    // apb response: one setup cycle, answer ready in access cycle
    // no wait states; pready stands in the access cycle only
    s_d.pready = psel & ~penable;
    if (psel & ~penable) begin
      s_d.prdata  = pwrite ? `READ_ZERO : readWord;
      s_d.pslverr = ~addrMapped(paddr);
    end else if (accessDone) begin
      s_d.prdata  = `READ_ZERO;
      s_d.pslverr = 1'b0;
    end


    // prescaler restarts whenever the timer is halted
    if (!running || prescaleTick) begin
      s_d.prescale = `PRESCALE_ZERO;
    end else begin
      s_d.prescale = s_q.prescale + `PRESCALE_ONE;
    end


    // control register: software value, then hardware sets win
    // so an event in the clearing cycle is never lost
    ctlBase = wrControl ? pwdata[7:0] : s_q.timerControl;
    s_d.timerControl = ctlBase;
    // a software one on a flag simply sets it
    if (setOverflow) begin
      s_d.timerControl[`BIT_OVERFLOW] = 1'b1;
    end
    if (setExtEdge) begin
      s_d.timerControl[`BIT_EXT_EDGE] = 1'b1;
    end


    // clock control is software-only
    if (wrClockCtrl) begin
      s_d.clockControl = pwdata[7:0];
    end


    // count update: reload, then increment; halted count holds except for a trigger reload
    if (doReload) begin
      s_d.countVal = s_q.reloadVal;
    end else if (countTick) begin
      s_d.countVal = s_q.countVal + `COUNT_ONE;
    end
    // software byte writes take precedence over counting
    // so firmware can preset a running count
    if (wrCountLow) begin
      s_d.countVal[7:0] = pwdata[7:0];
    end
    if (wrCountHigh) begin
      s_d.countVal[15:8] = pwdata[7:0];
    end


    // capture beats a simultaneous software write of the reload
    if (wrReloadLow) begin
      s_d.reloadVal[7:0] = pwdata[7:0];
    end
    if (wrReloadHigh) begin
      s_d.reloadVal[15:8] = pwdata[7:0];
    end
    if (doCapture) begin
      s_d.reloadVal = s_q.countVal;
    end


    // interrupt request follows either flag when enabled,
    // from the next value so it rises with the flag
    s_d.timerIrq = s_d.clockControl[`BIT_IRQ_ENABLE] &
                   (s_d.timerControl[`BIT_OVERFLOW] |
                    s_d.timerControl[`BIT_EXT_EDGE]);


    // serial timebase: this timer's rollover or first timer's
    s_d.rxBaudTick = s_q.timerControl[`BIT_RX_BAUD] ?
                     rollover : timer1Overflow;
    s_d.txBaudTick = s_q.timerControl[`BIT_TX_BAUD] ?
                     rollover : timer1Overflow;
  end

  // ============================================================
  // state register
  // clkEn low freezes every field, bus answer included
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{timerControl: `CONTROL_RESET,
               clockControl: `CLKCTRL_RESET,
               countVal:     `COUNT_RESET,
               reloadVal:    `COUNT_RESET,
               prescale:     `PRESCALE_ZERO,
               prdata:       `READ_ZERO,
               pready:       1'b0,
               pslverr:      1'b0,
               timerIrq:     1'b0,
               rxBaudTick:   1'b0,
               txBaudTick:   1'b0};
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs, all straight from the state register
  // no logic after the flops keeps output timing clean
  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign timerIrq   = s_q.timerIrq;
  assign rxBaudTick = s_q.rxBaudTick;
  assign txBaudTick = s_q.txBaudTick;

endmodule : reload_capture_timer

`default_nettype wire

/* test/reload_timer_checker_assertions.sv */
// port-level assertions for the reload/capture timer
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_params.svh"
module reload_timer_checker
  import reload_timer_pkg::*;
(
  input wire logic [`APB_AW-1:0] paddr,
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               clkEn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [`APB_DW-1:0] pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [`APB_DW-1:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               timer1Overflow,
  input wire logic               timerIrq,
  input wire logic               rxBaudTick,
  input wire logic               txBaudTick
);
  // ==========================================================
  // mirror of software-owned bits
  logic [7:0] ctlMirror_q;
  logic       ienMirror_q;
  wire logic  wrDone = psel && penable && pready && pwrite && pstrb[0]
                       && clkEn;
  wire logic  wrCtl = wrDone && paddr == `OFF_TIMER_CONTROL;
  wire logic  mapped = paddr >= `OFF_TIMER_CONTROL
                    && paddr <= `OFF_CLOCK_CONTROL && paddr[1:0] == 2'h0;
  // only bits 5:2 matter here; hardware never changes them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlMirror_q <= 8'h00;
      ienMirror_q <= 1'b0;
    end else begin
      if (wrCtl) ctlMirror_q <= pwdata[7:0];
      if (wrDone && paddr == `OFF_CLOCK_CONTROL) ienMirror_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus answer
  a_ready_after_setup: assert property (psel && !penable && clkEn |=> pready)
    else $error("no ready after setup");
  a_unmapped_err: assert property (
    psel && !penable && clkEn && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // ==========================================================
  // interrupt
  a_irq_masked: assert property (!ienMirror_q |-> !timerIrq)
    else $error("irq while disabled");
  a_force_ovf: assert property (
    wrCtl && pwdata[7] && ienMirror_q |=> timerIrq)
    else $error("overflow write did not raise irq");
  a_force_edge: assert property (
    wrCtl && pwdata[6] && ienMirror_q |=> timerIrq)
    else $error("edge flag write did not raise irq");
  // ==========================================================
  // baud timebase
  a_rx_from_t1: assert property (
    !ctlMirror_q[5] && clkEn |=> rxBaudTick == $past(timer1Overflow))
    else $error("rx tick not from timer1");
  a_tx_from_t1: assert property (
    !ctlMirror_q[4] && clkEn |=> txBaudTick == $past(timer1Overflow))
    else $error("tx tick not from timer1");
  a_baud_spacing: assert property (
    ctlMirror_q[5] && rxBaudTick |=> !rxBaudTick)
    else $error("baud ticks closer than two clocks");
  a_halt_still: assert property (
    ctlMirror_q[5] && !ctlMirror_q[2] && !$past(ctlMirror_q[2]) |-> !rxBaudTick)
    else $error("baud tick while halted");
  c_err: cover property (pslverr);
  c_rx: cover property (ctlMirror_q[5] && rxBaudTick);
  c_irq: cover property ($rose(timerIrq));
endmodule : reload_timer_checker

bind reload_capture_timer reload_timer_checker u_chk (
  .paddr(paddr), .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1Overflow(timer1Overflow), .timerIrq(timerIrq),
  .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick));
`default_nettype wire

/* test/pin_source.sv */
// pin and first-timer sources facing the timer's external inputs
`timescale 1ns/100ps
`default_nettype none
module pin_source (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] kick,
  output logic            triggerPin,
  output logic            countInputPin,
  output logic            timer1Overflow
);
  logic [2:0] trigLow_q;
  logic [2:0] cntLow_q;
  // ==========================================================
  // pins idle high; a kick holds one low four cycles, longer than the
  // synchroniser needs, so each kick is exactly one falling edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigLow_q      <= 3'h0;
      cntLow_q       <= 3'h0;
      timer1Overflow <= 1'b0;
    end else begin
      if (kick[0]) trigLow_q <= 3'h4;
      else if (trigLow_q != 3'h0) trigLow_q <= trigLow_q - 3'h1;
      if (kick[1]) cntLow_q <= 3'h4;
      else if (cntLow_q != 3'h0) cntLow_q <= cntLow_q - 3'h1;
      timer1Overflow <= kick[2]; // one-cycle pulse
    end
  end
  assign triggerPin    = trigLow_q == 3'h0;
  assign countInputPin = cntLow_q == 3'h0;
endmodule : pin_source
`default_nettype wire

/* test/test_sixteen_bit_reload_capture_timer.sv */
// self-checking bench for the reload/capture timer
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_params.svh"
module test_sixteen_bit_reload_capture_timer
  import reload_timer_pkg::*;
;
  logic core_clk, rst_n, clkEn, psel, penable, pwrite, pslverr, pready;
  logic countInputPin, triggerPin, timer1Overflow;
  logic timerIrq, rxBaudTick, txBaudTick, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  kick;
  logic [15:0] v, w;
  int          nMismatch, checkCount, cycles, seed, txCount;

  reload_capture_timer dut (.paddr(paddr), .core_clk(core_clk),
    .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .countInputPin(countInputPin),
    .triggerPin(triggerPin), .timer1Overflow(timer1Overflow),
    .timerIrq(timerIrq), .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick));
  pin_source u_src (.core_clk(core_clk), .rst_n(rst_n), .kick(kick),
    .triggerPin(triggerPin), .countInputPin(countInputPin),
    .timer1Overflow(timer1Overflow));

  // ==========================================================
  // clock, timeout and tick counting
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      finish_test();
    end
  end
  always @(negedge core_clk) if (txBaudTick === 1'b1) txCount++;

  // ==========================================================
  // helpers
  function automatic int baudPeriod(input logic [15:0] rl);
    return (32'h10000 - rl) * `DIV_BAUD;
  endfunction : baudPeriod
  task automatic check(input string name, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    check(n, rd, {24'h0, x});
  endtask : rdc
  task automatic irqIs(input logic x);
    @(negedge core_clk);
    check("irq", timerIrq, x);
  endtask : irqIs
  task automatic fire(input logic [2:0] m);
    @(posedge core_clk);
    kick <= m;
    @(posedge core_clk);
    kick <= 3'h0;
    repeat (10) @(posedge core_clk);
  endtask : fire
  task automatic finish_test();
    if (nMismatch == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence
  initial begin
    int k;
    int n;
    seed = 67;
    rst_n = 1'b0;
    clkEn = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    kick = 3'h0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdc("reset", 12'h0C8 + 12'(4 * i), 8'h00);
    end
    apb(1'b0, 12'h0E0, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    repeat (4) begin
      v = 16'($random(seed));
      wr(`OFF_RELOAD_LOW, v[7:0]);
      wr(`OFF_RELOAD_HIGH, v[15:8]);
      pstrb <= 4'h0;
      wr(`OFF_RELOAD_LOW, ~v[7:0]);
      pstrb <= 4'hF;
      rdc("reload lo", `OFF_RELOAD_LOW, v[7:0]);
      rdc("reload hi", `OFF_RELOAD_HIGH, v[15:8]);
    end
    // capture while halted: count copied to reload, edge flag set
    v = 16'($random(seed));
    w = 16'($random(seed));
    wr(`OFF_TIMER_CONTROL, 8'h09);
    wr(`OFF_COUNT_LOW, v[7:0]);
    wr(`OFF_COUNT_HIGH, v[15:8]);
    fire(3'h1);
    rdc("cap lo", `OFF_RELOAD_LOW, v[7:0]);
    rdc("cap hi", `OFF_RELOAD_HIGH, v[15:8]);
    rdc("ctl cap", `OFF_TIMER_CONTROL, 8'h49);
    wr(`OFF_TIMER_CONTROL, 8'h01);
    wr(`OFF_COUNT_LOW, w[7:0]);
    fire(3'h1);
    rdc("no cap", `OFF_RELOAD_LOW, v[7:0]);
    rdc("ctl off", `OFF_TIMER_CONTROL, 8'h01);
    // trigger reload loads the full reload value
    wr(`OFF_TIMER_CONTROL, 8'h08);
    wr(`OFF_COUNT_HIGH, w[15:8]);
    fire(3'h1);
    rdc("rld lo", `OFF_COUNT_LOW, v[7:0]);
    rdc("rld hi", `OFF_COUNT_HIGH, v[15:8]);
    rdc("ctl rld", `OFF_TIMER_CONTROL, 8'h48);
    // software-set flags force the interrupt only when enabled
    wr(`OFF_CLOCK_CONTROL, 8'h01);
    wr(`OFF_TIMER_CONTROL, 8'h80);
    irqIs(1'b1);
    wr(`OFF_TIMER_CONTROL, 8'h00);
    irqIs(1'b0);
    wr(`OFF_TIMER_CONTROL, 8'h40);
    irqIs(1'b1);
    wr(`OFF_CLOCK_CONTROL, 8'h00);
    irqIs(1'b0);
    // rollover reloads FFF0 and raises the flag; edge flag cleared
    // first so the enable write cannot raise the irq by itself
    wr(`OFF_TIMER_CONTROL, 8'h00);
    wr(`OFF_RELOAD_LOW, 8'hF0);
    wr(`OFF_RELOAD_HIGH, 8'hFF);
    wr(`OFF_COUNT_LOW, 8'hFD);
    wr(`OFF_COUNT_HIGH, 8'hFF);
    wr(`OFF_CLOCK_CONTROL, 8'h21);
    wr(`OFF_TIMER_CONTROL, 8'h04);
    irqIs(1'b0);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (timerIrq !== 1'b1 && k < 200);
    check("ovf irq", timerIrq, 1'b1);
    rdc("ctl ovf", `OFF_TIMER_CONTROL, 8'h84);
    wr(`OFF_TIMER_CONTROL, 8'h00);
    irqIs(1'b0);
    rdc("after wrap", `OFF_COUNT_HIGH, 8'hFF);
    apb(1'b0, `OFF_COUNT_LOW, 32'h0);
    w = rd[15:0];
    check("wrap lo", {31'h0, w >= 16'h00F0}, 32'h1);
    repeat (50) @(posedge core_clk);
    rdc("halted", `OFF_COUNT_LOW, w[7:0]);
    // counter mode: one increment per pin falling edge
    wr(`OFF_COUNT_LOW, 8'h00);
    wr(`OFF_COUNT_HIGH, 8'h00);
    wr(`OFF_TIMER_CONTROL, 8'h06);
    n = 1 + ($unsigned($random(seed)) % 8);
    repeat (n) fire(3'h2);
    wr(`OFF_TIMER_CONTROL, 8'h00);
    rdc("events", `OFF_COUNT_LOW, 8'(n));
    // baud mode: two clocks a tick, reload despite capture select
    wr(`OFF_RELOAD_LOW, 8'hFC);
    wr(`OFF_COUNT_LOW, 8'hFC);
    wr(`OFF_COUNT_HIGH, 8'hFF);
    wr(`OFF_TIMER_CONTROL, 8'h35);
    k = 0;
    while (rxBaudTick !== 1'b1 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (rxBaudTick !== 1'b1 && k < 100);
    check("baud gap", k, baudPeriod(16'hFFFC));
    fire(3'h1);
    rdc("ctl baud", `OFF_TIMER_CONTROL, 8'h35);
    wr(`OFF_TIMER_CONTROL, 8'h24);
    // let a rollover tick launched by the write edge drain first
    @(posedge core_clk);
    txCount = 0;
    fire(3'h4);
    check("tx ticks", txCount, 1);
    wr(`OFF_TIMER_CONTROL, 8'h20);
    repeat (20) @(posedge core_clk);
    wr(`OFF_TIMER_CONTROL, 8'h00);
    // capture mode at slow ticks: overflow flags, count wraps to 0
    wr(`OFF_COUNT_LOW, 8'hFE);
    wr(`OFF_COUNT_HIGH, 8'hFF);
    wr(`OFF_CLOCK_CONTROL, 8'h01);
    wr(`OFF_TIMER_CONTROL, 8'h05);
    repeat (40) @(posedge core_clk);
    irqIs(1'b1);
    rdc("ctl cap ovf", `OFF_TIMER_CONTROL, 8'h85);
    wr(`OFF_TIMER_CONTROL, 8'h01);
    rdc("cap wrap", `OFF_COUNT_HIGH, 8'h00);
    finish_test();
  end
endmodule : test_sixteen_bit_reload_capture_timer
`default_nettype wire
